// file: rtl/pira_pkg.sv
// Package with constants and carriers for the process image register access block
package pira_pkg;

  // ==========================================================================
  // Image layout
  // ==========================================================================
  localparam int unsigned CTRL_BYTE_OFS = 0;    // Control byte position in output image
  localparam int unsigned STATUS_BYTE_OFS = 0;  // Status byte position in input image
  localparam int unsigned DATA_HI_BYTE = 1;     // First data byte carries the high byte
  localparam int unsigned DATA_LO_BYTE = 2;     // Second data byte carries the low byte
  localparam int unsigned MODE_BIT = 7;         // Register mode bit of control and status
  localparam int unsigned DIR_BIT = 6;          // Direction bit, one means write
  localparam int unsigned IDX_MSB = 5;          // Top bit of the register index field
  localparam int unsigned IDX_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_COUNT = 64;

  // ==========================================================================
  // Register areas and special registers
  // ==========================================================================
  localparam logic [5:0] RAM_LAST_IDX = 6'h07;
  localparam logic [5:0] ROM_FIRST_IDX = 6'h08;
  localparam logic [5:0] ROM_LAST_IDX = 6'h0f;
  localparam logic [5:0] TYPE_IDX = 6'h08;
  localparam logic [5:0] VERSION_IDX = 6'h09;
  localparam logic [5:0] MFR_FIRST_IDX = 6'h10;
  localparam logic [5:0] MFR_LAST_IDX = 6'h1e;
  localparam logic [5:0] CODE_WORD_IDX = 6'h1f;
  localparam logic [5:0] FEATURE_IDX = 6'h20;
  localparam logic [5:0] USER_LAST_IDX = 6'h2f;
  localparam logic [15:0] CODE_WORD = 16'h1235;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] data;
  } pira_out_img_t;

  typedef struct packed {
    logic [7:0] status;
    logic [15:0] data;
  } pira_in_img_t;

  typedef enum logic [1:0] {
    AREA_RAM,
    AREA_ROM,
    AREA_GUARDED,
    AREA_FREE
  } pira_area_t;

  // Classifies a register index into its access area
  function automatic pira_area_t area_of(input logic [5:0] idx);
    pira_area_t a;
    a = AREA_FREE;
    if (idx <= RAM_LAST_IDX) begin
      a = AREA_RAM;
    end else if (idx <= ROM_LAST_IDX) begin
      a = AREA_ROM;
    end else if (idx <= USER_LAST_IDX && idx != CODE_WORD_IDX) begin
      a = AREA_GUARDED;
    end
    return a;
  endfunction

endpackage

// file: rtl/pira_reg_store.sv
// Word store for the 64 register locations with one write and two read ports
`timescale 1ns/1ps
module pira_reg_store #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned WIDTH = 16,
  parameter int unsigned AW = 6
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  input wire logic [AW-1:0] peek_idx,
  output logic [WIDTH-1:0] peek_data
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Contents survive the logic reset, like the retained parameter memory
  // Cleared once at load time by the declaration, so only the write port drives it
  logic [WIDTH-1:0] mem [DEPTH] = '{default: '0};

  if (DEPTH != (1 << AW)) begin : g_chk
    $error("pira_reg_store: depth must equal two to the index width");
  end

  // Single write port
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Two asynchronous read ports
  assign rd_data = mem[rd_idx];
  assign peek_data = mem[peek_idx];

endmodule

// file: rtl/pira_top.sv
// Register access through the cyclic process image of a fieldbus I/O module
//
// Operation
// - Control byte bit 7 set turns both data bytes into register access
// - Control bit 6 clear reads without change, set writes the data word
// - Control bits 5 to 0 select one of 64 registers
// - Status bit 7 acknowledges register mode, bits 5 to 0 echo the index
// - Data word is ignored on reads; master places write value there
// - Read result returned with high byte first, low byte second
// - Writing 0x1235 to the code word register lifts write protection
// - Writing any other value there restores protection at once
// - Feature register settings take effect only after the next power-on
// - Code word register reads the code when open, zero when protected
// - Registers 16 to 47, except 31, refuse writes unless the code word is held
`timescale 1ns/1ps
module pira_top #(
  parameter logic [15:0] TYPE_CODE = 16'h0abc,    // Arbitrary identity value
  parameter logic [15:0] VERSION_CODE = 16'h3130, // Arbitrary version value
  parameter int unsigned REG_COUNT = pira_pkg::REG_COUNT,
  parameter int unsigned DATA_W = pira_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic exch_strobe,
  input wire pira_pkg::pira_out_img_t out_img,
  input wire logic [15:0] proc_in_data,
  input wire logic [6:0] proc_in_status,
  output pira_pkg::pira_in_img_t in_img,
  output logic in_img_valid,
  output logic [15:0] proc_out_data,
  output logic [6:0] proc_out_ctrl,
  output logic [15:0] feature_mode,
  output logic write_open,
  output logic write_refused
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (REG_COUNT != pira_pkg::REG_COUNT) begin : g_chk_count
    $error("pira_top: register count must be 64");
  end
  if (DATA_W != pira_pkg::DATA_W) begin : g_chk_width
    $error("pira_top: data word must be 16 bits");
  end

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DECODE,
    ST_REPLY,
    ST_BOOT
  } pira_state_t;

  pira_state_t state_q;
  pira_state_t state_d;

  // ==========================================================================
  // Request capture
  // ==========================================================================
  pira_pkg::pira_out_img_t req_q;
  pira_pkg::pira_out_img_t req_d;

  // Control byte fields of the held request
  wire logic reg_mode;
  wire logic is_write;
  wire logic [5:0] req_idx;
  wire logic [15:0] req_word;

  assign reg_mode = req_q.ctrl[pira_pkg::MODE_BIT];
  assign is_write = req_q.ctrl[pira_pkg::DIR_BIT];
  assign req_idx = req_q.ctrl[pira_pkg::IDX_MSB:0];
  assign req_word = req_q.data;

  // ==========================================================================
  // Protection state and boot-time feature capture
  // ==========================================================================
  logic open_q;
  logic open_d;
  logic [15:0] feature_q;
  logic [15:0] feature_d;

  // ==========================================================================
  // Answer registers
  // ==========================================================================
  pira_pkg::pira_in_img_t ans_q;
  pira_pkg::pira_in_img_t ans_d;
  logic ans_valid_q;
  logic ans_valid_d;
  logic refused_q;
  logic refused_d;
  logic [15:0] pout_q;
  logic [15:0] pout_d;
  logic [6:0] pctrl_q;
  logic [6:0] pctrl_d;

  // ==========================================================================
  // Register store
  // ==========================================================================
  wire logic [15:0] store_rd;
  wire logic [15:0] store_feature;
  wire logic store_wr;

  pira_reg_store #(
    .DEPTH(REG_COUNT),
    .WIDTH(DATA_W),
    .AW(pira_pkg::IDX_W)
  ) u_store (
    .sys_clk(sys_clk),
    .wr_en(store_wr),
    .wr_idx(req_idx),
    .wr_data(req_word),
    .rd_idx(req_idx),
    .rd_data(store_rd),
    .peek_idx(pira_pkg::FEATURE_IDX),
    .peek_data(store_feature)
  );

  // ==========================================================================
  // Access decode
  // ==========================================================================
  wire pira_pkg::pira_area_t area;
  wire logic is_code_reg;
  wire logic in_decode;
  wire logic write_ok;
  wire logic write_denied;

  assign area = pira_pkg::area_of(req_idx);
  assign is_code_reg = (req_idx == pira_pkg::CODE_WORD_IDX);
  assign in_decode = (state_q == ST_DECODE) && reg_mode;

  // Guarded areas need the code word; the fixed area never takes writes
  assign write_ok = (area == pira_pkg::AREA_RAM) ||
                    (area == pira_pkg::AREA_FREE) ||
                    ((area == pira_pkg::AREA_GUARDED) && open_q);
  assign write_denied = in_decode && is_write && !is_code_reg && !write_ok;

  // The code word register itself lives in the protection flag, not the store
  assign store_wr = in_decode && is_write && !is_code_reg && write_ok;

  // ==========================================================================
  // Read value selection
  // ==========================================================================
  wire logic [15:0] fixed_word;
  wire logic [15:0] code_readback;
  wire logic [15:0] read_word;

  // Fixed identity words in the read-only area
  assign fixed_word = (req_idx == pira_pkg::TYPE_IDX) ? TYPE_CODE :
                      (req_idx == pira_pkg::VERSION_IDX) ? VERSION_CODE :
                      pira_pkg::ZERO_WORD;

  // Code word reads back only while protection is off
  assign code_readback = open_q ? pira_pkg::CODE_WORD : pira_pkg::ZERO_WORD;

  assign read_word = is_code_reg ? code_readback :
                     (area == pira_pkg::AREA_ROM) ? fixed_word :
                     store_rd;

  // ==========================================================================
  // Reply value selection
  // ==========================================================================
  wire logic [15:0] next_code_readback;
  wire logic [15:0] write_reply;
  wire logic [15:0] reg_reply;
  wire logic [7:0] reg_status;
  wire logic [7:0] proc_status;

  // After a write the reply shows what the register now holds
  assign next_code_readback = (req_word == pira_pkg::CODE_WORD) ?
                              pira_pkg::CODE_WORD : pira_pkg::ZERO_WORD;
  assign write_reply = is_code_reg ? next_code_readback :
                       write_ok ? req_word : read_word;

  // Read ignores the output data word entirely
  assign reg_reply = is_write ? write_reply : read_word;

  // Acknowledge bit, read bit clear, echoed index
  assign reg_status = {1'b1, 1'b0, req_idx};

  // Process status with the mode bit held clear
  assign proc_status = {1'b0, proc_in_status};

  // ==========================================================================
  // Next state and data
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    open_d = open_q;
    feature_d = feature_q;
    ans_d = ans_q;
    ans_valid_d = 1'b0;
    refused_d = 1'b0;
    pout_d = pout_q;
    pctrl_d = pctrl_q;
    case (state_q)
      ST_BOOT: begin
        // Feature setting is latched only once after power-on
        feature_d = store_feature;
        state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (exch_strobe) begin
          req_d = out_img;
          state_d = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (reg_mode) begin
          if (is_write && is_code_reg) begin
            // Only the exact code word opens; anything else closes at once
            open_d = (req_word == pira_pkg::CODE_WORD);
          end
          refused_d = write_denied;
          ans_d.status = reg_status;
          ans_d.data = reg_reply;
        end else begin
          // Process data passes both ways while register mode is off
          pout_d = req_word;
          pctrl_d = req_q.ctrl[6:0];
          ans_d.status = proc_status;
          ans_d.data = proc_in_data;
        end
        state_d = ST_REPLY;
      end
      ST_REPLY: begin
        ans_valid_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  // Sequencer and request hold
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_BOOT;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
    end
  end

  // Protection comes up active after every power-on
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      open_q <= 1'b0;
      feature_q <= pira_pkg::ZERO_WORD;
    end else begin
      open_q <= open_d;
      feature_q <= feature_d;
    end
  end

  // Answer image and its strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ans_q <= '0;
      ans_valid_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      ans_q <= ans_d;
      ans_valid_q <= ans_valid_d;
      refused_q <= refused_d;
    end
  end

  // Process outputs hold through register mode exchanges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pout_q <= pira_pkg::ZERO_WORD;
      pctrl_q <= '0;
    end else begin
      pout_q <= pout_d;
      pctrl_q <= pctrl_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign in_img = ans_q;
  assign in_img_valid = ans_valid_q;
  assign proc_out_data = pout_q;
  assign proc_out_ctrl = pctrl_q;
  assign feature_mode = feature_q;
  assign write_open = open_q;
  assign write_refused = refused_q;

endmodule

// file: verification/pira_master_model.sv
// Fieldbus master model that launches output images toward the block
`timescale 1ns/1ps
module pira_master_model (
  input wire logic sys_clk,
  input wire logic send,
  input wire pira_pkg::pira_out_img_t send_img,
  output logic exch_strobe,
  output pira_pkg::pira_out_img_t out_img = '0
);
  // One exchange per send, image scrambled outside the exchange
  always_ff @(posedge sys_clk) begin
    exch_strobe <= send;
    out_img <= send ? send_img : ~out_img;
  end
endmodule

// file: verification/pira_assertions.sv
// Checker for the process image register access block
`timescale 1ns/1ps
module pira_checker #(
  parameter logic [15:0] TYPE_CODE = 16'h0abc
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic exch_strobe,
  input wire pira_pkg::pira_out_img_t out_img,
  input wire logic [15:0] proc_in_data,
  input wire logic [6:0] proc_in_status,
  input wire pira_pkg::pira_in_img_t in_img,
  input wire logic in_img_valid,
  input wire logic [15:0] proc_out_data,
  input wire logic [6:0] proc_out_ctrl,
  input wire logic [15:0] feature_mode,
  input wire logic write_open,
  input wire logic write_refused
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic rdy_q;
  logic rdy2_q;
  logic [1:0] cnt_q;
  wire [7:0] c = out_img.ctrl;
  wire take = rst_n && rdy_q && exch_strobe && cnt_q == 2'h0;
  wire wr = take && c[7:6] == 2'b11;
  // Tracks reset release and the busy window after a take
  always_ff @(posedge sys_clk) begin
    rdy_q <= rst_n;
    rdy2_q <= rst_n && rdy_q;
    cnt_q <= !rst_n ? 2'h0 : take ? 2'h2 : (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  valid_delay_a: assert property (take |-> ##3 in_img_valid)
    else $error("answer pulse missing after take");
  valid_cause_a: assert property (in_img_valid |-> $past(take, 3))
    else $error("answer pulse without take");
  status_echo_a: assert property (take && c[7] |-> ##2 in_img.status == {2'b10, $past(c[5:0], 2)})
    else $error("status does not echo index");
  nonreg_pass_a: assert property (take && !c[7] |-> ##2 !in_img.status[7] && proc_out_data == $past(out_img.data, 2))
    else $error("process data path wrong");
  code_open_a: assert property (wr && c[5:0] == 6'h1f && out_img.data == pira_pkg::CODE_WORD |-> ##2 write_open)
    else $error("code word did not open");
  code_close_a: assert property (wr && c[5:0] == 6'h1f && out_img.data != pira_pkg::CODE_WORD |-> ##2 !write_open)
    else $error("other value did not close");
  code_read_a: assert property (take && c == 8'h9f |-> ##2 in_img.data == (write_open ? pira_pkg::CODE_WORD : pira_pkg::ZERO_WORD))
    else $error("code register read wrong");
  guard_refuse_a: assert property (wr && c[5:0] >= 6'h10 && c[5:0] <= 6'h1e && !write_open |-> ##2 write_refused)
    else $error("guarded write not refused");
  free_accept_a: assert property (wr && c[5:4] == 2'b11 |-> ##2 !write_refused)
    else $error("free write refused");
  type_read_a: assert property (take && c == 8'h88 |-> ##2 in_img.data == TYPE_CODE)
    else $error("type read wrong");
  feature_hold_a: assert property (rdy2_q && $past(rdy2_q) |-> $stable(feature_mode))
    else $error("feature changed without reset");
  // Main scenarios
  open_c: cover property (wr && c[5:0] == 6'h1f && out_img.data == pira_pkg::CODE_WORD);
  refuse_c: cover property (write_refused);
  nonreg_c: cover property (take && !c[7]);
endmodule

bind pira_top pira_checker #(.TYPE_CODE(TYPE_CODE)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .exch_strobe(exch_strobe), .out_img(out_img), .proc_in_data(proc_in_data),
  .proc_in_status(proc_in_status), .in_img(in_img), .in_img_valid(in_img_valid),
  .proc_out_data(proc_out_data), .proc_out_ctrl(proc_out_ctrl), .feature_mode(feature_mode),
  .write_open(write_open), .write_refused(write_refused));

// file: verification/pira_top_test.sv
// Self-checking testbench for the process image register access block
`timescale 1ns/1ps
module pira_top_test;
  localparam logic [15:0] TYPE_V = 16'h0abc; // Arbitrary identity value
  localparam logic [15:0] VER_V = 16'h3130; // Arbitrary version value
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic send = 1'b0;
  pira_pkg::pira_out_img_t send_img = '0;
  logic [15:0] proc_in_data = 16'h0000;
  logic [6:0] proc_in_status = 7'h00;
  logic exch_strobe, in_img_valid, write_open, write_refused;
  pira_pkg::pira_out_img_t out_img;
  pira_pkg::pira_in_img_t in_img;
  logic [15:0] proc_out_data, feature_mode;
  logic [6:0] proc_out_ctrl;
  logic [24:0] exp_q[$];
  logic [15:0] mem [64];
  logic open_m = 1'b0;
  logic ref_q = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  pira_master_model mst_u (.sys_clk(sys_clk), .send(send), .send_img(send_img),
    .exch_strobe(exch_strobe), .out_img(out_img));
  pira_top #(.TYPE_CODE(TYPE_V), .VERSION_CODE(VER_V)) dut_u (.sys_clk(sys_clk),
    .rst_n(rst_n), .exch_strobe(exch_strobe), .out_img(out_img),
    .proc_in_data(proc_in_data), .proc_in_status(proc_in_status), .in_img(in_img),
    .in_img_valid(in_img_valid), .proc_out_data(proc_out_data),
    .proc_out_ctrl(proc_out_ctrl), .feature_mode(feature_mode), .write_open(write_open),
    .write_refused(write_refused));

  // Clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [24:0] exp, input logic [24:0] act);
    total_checks++;
    if (act !== exp) begin
      num_errors++;
      $display("ERROR at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Launches one exchange and notes its expected answer
  task automatic xchg(input logic [7:0] c, input logic [15:0] d, input logic [24:0] e);
    exp_q.push_back(e);
    send_img <= '{ctrl: c, data: d};
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Register access with the expected reply worked out alongside
  task automatic reg_op(input logic w, input logic [5:0] i, input logic [15:0] d);
    logic [15:0] r;
    logic f;
    f = 1'b0;
    if (i == 6'h1f) begin
      if (w) open_m = (d == pira_pkg::CODE_WORD);
      r = open_m ? pira_pkg::CODE_WORD : pira_pkg::ZERO_WORD;
    end else if (i == 6'h08 || i == 6'h09) begin
      f = w;
      r = (i == 6'h08) ? TYPE_V : VER_V;
    end else begin
      f = w && !open_m && i >= 6'h10 && i <= 6'h2f;
      if (w && !f) mem[i] = d;
      r = mem[i];
    end
    xchg({1'b1, w, i}, d, {2'b10, i, r, f});
  endtask

  // Compares each answer with the oldest note
  always @(posedge sys_clk) begin
    if (in_img_valid === 1'b1) begin
      check(exp_q.size() != 0 ? exp_q.pop_front() : ~{in_img, ref_q}, {in_img, ref_q});
    end
    ref_q <= write_refused;
  end

  // Cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    logic [15:0] v;
    logic [6:0] s;
    logic [6:0] pc;
    logic [15:0] d;
    void'($urandom(32'h0ac0));
    for (int k = 0; k < 64; k++) mem[k] = 16'h0000;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Identity reads and refused write to the fixed area
    reg_op(1'b0, 6'h08, 16'($urandom));
    reg_op(1'b0, 6'h09, 16'($urandom));
    reg_op(1'b1, 6'h08, 16'h5a5a);
    $display("test identity done");
    // Protection sequence around the code word
    reg_op(1'b1, 6'h14, 16'h1111);
    reg_op(1'b1, 6'h1f, 16'h1235);
    reg_op(1'b0, 6'h1f, 16'($urandom));
    reg_op(1'b1, 6'h20, 16'h0002);
    reg_op(1'b0, 6'h20, 16'($urandom));
    reg_op(1'b1, 6'h14, 16'h2222);
    reg_op(1'b1, 6'h1f, 16'h1234);
    reg_op(1'b0, 6'h1f, 16'($urandom));
    reg_op(1'b1, 6'h1e, 16'h3333);
    reg_op(1'b1, 6'h1f, 16'h0000);
    $display("test protection done");
    // Process data passes while register mode is off
    repeat (4) begin
      v = 16'($urandom);
      s = 7'($urandom);
      d = 16'($urandom);
      pc = 7'($urandom);
      proc_in_data <= v;
      proc_in_status <= s;
      xchg({1'b0, pc}, d, {1'b0, s, v, 1'b0});
      @(negedge sys_clk);
      check({9'h000, d}, {9'h000, proc_out_data});
      check({18'h0_0000, pc}, {18'h0_0000, proc_out_ctrl});
      @(posedge sys_clk);
    end
    $display("test process data done");
    // Random traffic to the always-writable areas
    repeat (24) begin
      v = 16'($urandom);
      reg_op(v[15], v[14] ? {3'b000, v[2:0]} : {2'b11, v[3:0]}, 16'($urandom));
    end
    $display("test random done");
    // Feature value takes effect only after a fresh reset
    repeat (2) @(posedge sys_clk);
    check({9'h000, 16'h0000}, {9'h000, feature_mode});
    rst_n <= 1'b0;
    open_m = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check({9'h000, 16'h0002}, {9'h000, feature_mode});
    reg_op(1'b0, 6'h1f, 16'h1235);
    reg_op(1'b0, 6'h20, 16'($urandom));
    repeat (4) @(posedge sys_clk);
    $display("test power cycle done");
    close_out();
  end
endmodule
